// ===== rgd_pkg.sv
// package of constants and types for the rotate group datapath
// assumes one clock; t-states are one clock cycle each
package rgd_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam int REG_ADDR_W = 4;
    localparam int TCNT_W = 3;
    localparam int FIELD_W = 3;
    localparam int GROUP_W = 5;

    // ****************************************
    // opcode bytes
    // ****************************************
    localparam logic [7:0] OPC_ACC_LEFT_CIRC = 8'h07;
    localparam logic [7:0] OPC_ACC_RIGHT_CIRC = 8'h0F;
    localparam logic [7:0] OPC_ACC_LEFT_THRU = 8'h17;
    localparam logic [7:0] OPC_ACC_RIGHT_THRU = 8'h1F;
    localparam logic [7:0] OPC_BIT_PREFIX = 8'hCB;
    localparam logic [7:0] OPC_X_PREFIX = 8'hDD;
    localparam logic [7:0] OPC_Y_PREFIX = 8'hFD;
    localparam logic [7:0] OPC_COUNT_DOWN = 8'h2B;
    localparam logic [7:0] OPC_CIRC_MEM = 8'h06;
    localparam logic [4:0] OPC_CIRC_GROUP = 5'h00;

    // ****************************************
    // register field codes
    // ****************************************
    localparam logic [2:0] FIELD_H = 3'h4;
    localparam logic [2:0] FIELD_L = 3'h5;
    localparam logic [2:0] FIELD_MEM = 3'h6;
    localparam logic [2:0] FIELD_ACC = 3'h7;

    // ****************************************
    // t-state counts per machine cycle
    // ****************************************
    localparam logic [2:0] T_ZERO = 3'h0;
    localparam logic [2:0] T_ONE = 3'h1;
    localparam logic [2:0] T_CAP = 3'h1;
    localparam logic [2:0] T_FETCH = 3'h4;
    localparam logic [2:0] T_COUNT_DOWN = 3'h6;
    localparam logic [2:0] T_DISP = 3'h3;
    localparam logic [2:0] T_IDX_OPC = 3'h5;
    localparam logic [2:0] T_MREAD = 3'h4;
    localparam logic [2:0] T_MWRITE = 3'h3;

    // ****************************************
    // flag bit positions
    // ****************************************
    localparam int FLAG_S = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_H = 4;
    localparam int FLAG_PV = 2;
    localparam int FLAG_N = 1;
    localparam int FLAG_C = 0;

    // ****************************************
    // software register map
    // ****************************************
    localparam logic [3:0] RIX_GPR_TOP = 4'h7;
    localparam logic [3:0] RIX_FLAGS = 4'h6;
    localparam logic [3:0] RIX_X_LO = 4'h8;
    localparam logic [3:0] RIX_X_HI = 4'h9;
    localparam logic [3:0] RIX_Y_LO = 4'hA;
    localparam logic [3:0] RIX_Y_HI = 4'hB;
    localparam logic [3:0] RIX_PC_LO = 4'hC;
    localparam logic [3:0] RIX_PC_HI = 4'hD;
    localparam logic [3:0] RIX_CTRL = 4'hE;
    localparam logic [3:0] RIX_STATUS = 4'hF;
    localparam int CTRL_RUN = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_ILLEGAL = 1;
    localparam int STAT_RUN = 2;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        ROT_ACC_LEFT_CIRCULAR,
        ROT_ACC_LEFT_THRU_CARRY,
        ROT_ACC_RIGHT_CIRCULAR,
        ROT_ACC_RIGHT_THRU_CARRY,
        ROT_LEFT_CIRCULAR_OP
    } rgd_rot_op_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH1,
        ST_FETCH2,
        ST_DISP,
        ST_FETCH3,
        ST_MREAD,
        ST_MWRITE
    } rgd_state_t;

endpackage

// ===== rgd_rot_if.sv
// interface between the sequencer and the rotate unit
// assumes rgd_pkg is compiled first
`timescale 1ns/1ps
interface rgd_rot_if;
    import rgd_pkg::*;
    rgd_rot_op_t op;
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] flags_in;
    logic [DATA_W-1:0] result;
    logic [DATA_W-1:0] flags_out;
    modport unit (input op, input operand, input flags_in, output result, output flags_out);
    modport ctrl (output op, output operand, output flags_in, input result, input flags_out);
endinterface

// ===== rgd_rot_unit.sv
// combinational rotate and flag unit
// assumes the caller commits result and flags itself
`timescale 1ns/1ps
module rgd_rot_unit (
    // operands and results
    rgd_rot_if.unit rot
);
    import rgd_pkg::*;

    // ****************************************
    // rotate data movement
    // ****************************************
    wire [DATA_W-1:0] a = rot.operand;
    wire cin = rot.flags_in[FLAG_C];
    wire msb = a[DATA_W-1];
    wire lsb = a[0];
    wire [DATA_W-1:0] left_circ = {a[DATA_W-2:0], msb};
    wire [DATA_W-1:0] left_thru = {a[DATA_W-2:0], cin};
    wire [DATA_W-1:0] right_circ = {lsb, a[DATA_W-1:1]};
    wire [DATA_W-1:0] right_thru = {cin, a[DATA_W-1:1]};
    wire is_right = (rot.op == ROT_ACC_RIGHT_CIRCULAR) || (rot.op == ROT_ACC_RIGHT_THRU_CARRY);
    wire is_full = (rot.op == ROT_LEFT_CIRCULAR_OP);
    wire [DATA_W-1:0] res =
        (rot.op == ROT_ACC_LEFT_THRU_CARRY) ? left_thru :
        (rot.op == ROT_ACC_RIGHT_CIRCULAR) ? right_circ :
        (rot.op == ROT_ACC_RIGHT_THRU_CARRY) ? right_thru :
        left_circ;
    assign rot.result = res;

    // ****************************************
    // flags
    // ****************************************
    always_comb begin
        rot.flags_out = rot.flags_in;
        rot.flags_out[FLAG_H] = 1'b0;
        rot.flags_out[FLAG_N] = 1'b0;
        rot.flags_out[FLAG_C] = is_right ? lsb : msb;
        if (is_full) begin
            rot.flags_out[FLAG_S] = res[DATA_W-1];
            rot.flags_out[FLAG_Z] = (res == RST_BYTE);
            rot.flags_out[FLAG_PV] = ~^res;
        end
    end

endmodule

// ===== rgd_datapath.sv
// rotate group datapath: sequencer, registers and memory port
// assumes a memory that answers a read one cycle after the strobe
// and a software port with one-cycle strobes
//
// Contract
// - FD 2B counts Y down, 4+6 t-states
// - Y count-down leaves all flags alone
// - 07 rotates A left, bit7 to carry
// - 17 rotates A left through carry, 4t
// - acc rotates keep S Z PV, clear H N
// - acc right circular: bit0 to carry, bit7
// - 1F rotates A right through carry
// - CB 00000rrr rotates register, 4+4 t-states
// - register field codes; 110 means memory
// - prefixed rotate sets S Z PV C, clears H N
// - CB 06 rotates byte at pointer pair, 15t
// - DD CB d 06 rotates X plus displacement
// - FD CB d 06 rotates Y plus displacement
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module rgd_datapath (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // software register port
    input wire logic [rgd_pkg::REG_ADDR_W-1:0] i_reg_addr,
    input wire logic [rgd_pkg::DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [rgd_pkg::DATA_W-1:0] o_reg_rdata,
    // memory bus
    output logic [rgd_pkg::ADDR_W-1:0] o_mem_addr,
    output logic o_mem_rd,
    output logic o_mem_wr,
    output logic [rgd_pkg::DATA_W-1:0] o_mem_wdata,
    input wire logic [rgd_pkg::DATA_W-1:0] i_mem_rdata,
    // status
    output logic o_busy
);
    import rgd_pkg::*;

    // ****************************************
    // state
    // ****************************************
    rgd_state_t state_reg;
    rgd_state_t state_next;
    logic [TCNT_W-1:0] tcnt_reg;
    logic [TCNT_W-1:0] tcnt_next;
    logic [DATA_W-1:0] gpr_reg [0:7];
    logic [DATA_W-1:0] flag_reg;
    logic [ADDR_W-1:0] index_register_x_reg;
    logic [ADDR_W-1:0] index_register_y_reg;
    logic [ADDR_W-1:0] pc_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    logic [DATA_W-1:0] op1_reg;
    logic [DATA_W-1:0] op2_reg;
    logic [DATA_W-1:0] op3_reg;
    logic [DATA_W-1:0] disp_reg;
    logic [DATA_W-1:0] data_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic run_reg;
    logic illegal_reg;
    logic ev_bad;

    rgd_rot_if rot ();

    rgd_rot_unit u_rot (
        .rot(rot.unit)
    );

    // ****************************************
    // decode
    // ****************************************
    wire [TCNT_W-1:0] tlen;
    wire t_last = (tcnt_reg == tlen - T_ONE);
    wire t_first = (tcnt_reg == T_ZERO);
    wire t_cap = (tcnt_reg == T_CAP);
    wire is_idle = (state_reg == ST_IDLE);
    wire is_acc_op = (op1_reg == OPC_ACC_LEFT_CIRC) || (op1_reg == OPC_ACC_RIGHT_CIRC) ||
        (op1_reg == OPC_ACC_LEFT_THRU) || (op1_reg == OPC_ACC_RIGHT_THRU);
    wire is_bit_pfx = (op1_reg == OPC_BIT_PREFIX);
    wire is_idx_pfx = (op1_reg == OPC_X_PREFIX) || (op1_reg == OPC_Y_PREFIX);
    wire is_count_down = (op1_reg == OPC_Y_PREFIX) && (op2_reg == OPC_COUNT_DOWN);
    wire [FIELD_W-1:0] field = op2_reg[FIELD_W-1:0];
    wire circ_group = (op2_reg[DATA_W-1:FIELD_W] == OPC_CIRC_GROUP);
    wire field_mem = (field == FIELD_MEM);
    wire [ADDR_W-1:0] pointer_pair = {gpr_reg[FIELD_H], gpr_reg[FIELD_L]};
    wire [ADDR_W-1:0] idx_base =
        (op1_reg == OPC_X_PREFIX) ? index_register_x_reg : index_register_y_reg;
    wire [ADDR_W-1:0] disp_ext = {{(ADDR_W-DATA_W){disp_reg[DATA_W-1]}}, disp_reg};
    wire [ADDR_W-1:0] eff_addr = idx_base + disp_ext;

    // machine cycle lengths
    assign tlen =
        (state_reg == ST_FETCH2) ? (is_count_down ? T_COUNT_DOWN : T_FETCH) :
        (state_reg == ST_DISP) ? T_DISP :
        (state_reg == ST_FETCH3) ? T_IDX_OPC :
        (state_reg == ST_MREAD) ? T_MREAD :
        (state_reg == ST_MWRITE) ? T_MWRITE :
        T_FETCH;

    // ****************************************
    // execution events
    // ****************************************
    wire ev_acc = (state_reg == ST_FETCH1) && t_last && is_acc_op;
    wire ev_reg = (state_reg == ST_FETCH2) && t_last && is_bit_pfx && circ_group && !field_mem;
    wire ev_cnt = (state_reg == ST_FETCH2) && t_last && is_count_down;
    wire ev_mread_end = (state_reg == ST_MREAD) && t_last;
    wire ev_memw = (state_reg == ST_MWRITE) && t_last;
    wire ev_done = ev_acc || ev_reg || ev_cnt || ev_memw;
    wire ev_fetch = (state_reg == ST_FETCH1) || (state_reg == ST_FETCH2) ||
        (state_reg == ST_DISP) || (state_reg == ST_FETCH3);
    wire ev_pc_inc = ev_fetch && t_cap;
    wire sw_wr = i_reg_wr && is_idle;

    // rotate unit inputs
    assign rot.op =
        (state_reg != ST_FETCH1) ? ROT_LEFT_CIRCULAR_OP :
        (op1_reg == OPC_ACC_LEFT_THRU) ? ROT_ACC_LEFT_THRU_CARRY :
        (op1_reg == OPC_ACC_RIGHT_CIRC) ? ROT_ACC_RIGHT_CIRCULAR :
        (op1_reg == OPC_ACC_RIGHT_THRU) ? ROT_ACC_RIGHT_THRU_CARRY :
        ROT_ACC_LEFT_CIRCULAR;
    assign rot.operand =
        (state_reg == ST_FETCH1) ? gpr_reg[FIELD_ACC] :
        (state_reg == ST_FETCH2) ? gpr_reg[field] :
        data_reg;
    assign rot.flags_in = flag_reg;

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        ev_bad = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (run_reg) begin
                    state_next = ST_FETCH1;
                    addr_next = pc_reg;
                end
            end
            ST_FETCH1: begin
                if (t_last) begin
                    if (is_bit_pfx || is_idx_pfx) begin
                        state_next = ST_FETCH2;
                        addr_next = pc_reg;
                    end else if (!is_acc_op) begin
                        ev_bad = 1'b1;
                    end
                end
            end
            ST_FETCH2: begin
                if (t_last) begin
                    if (is_bit_pfx && circ_group && field_mem) begin
                        state_next = ST_MREAD;
                        addr_next = pointer_pair;
                    end else if (is_idx_pfx && (op2_reg == OPC_BIT_PREFIX)) begin
                        state_next = ST_DISP;
                        addr_next = pc_reg;
                    end else if (!(is_bit_pfx && circ_group) && !is_count_down) begin
                        ev_bad = 1'b1;
                    end
                end
            end
            ST_DISP: begin
                if (t_last) begin
                    state_next = ST_FETCH3;
                    addr_next = pc_reg;
                end
            end
            ST_FETCH3: begin
                if (t_last) begin
                    if (op3_reg == OPC_CIRC_MEM) begin
                        state_next = ST_MREAD;
                        addr_next = eff_addr;
                    end else begin
                        ev_bad = 1'b1;
                    end
                end
            end
            ST_MREAD: begin
                if (t_last) begin
                    state_next = ST_MWRITE;
                end
            end
            ST_MWRITE: begin
                state_next = ST_MWRITE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (ev_done || ev_bad) begin
            state_next = (run_reg && !ev_bad) ? ST_FETCH1 : ST_IDLE;
            addr_next = pc_reg;
        end
    end

    assign tcnt_next = (is_idle || t_last) ? T_ZERO : tcnt_reg + T_ONE;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_reg <= ST_IDLE;
            tcnt_reg <= T_ZERO;
            addr_reg <= RST_WORD;
        end else if (i_ce) begin
            state_reg <= state_next;
            tcnt_reg <= tcnt_next;
            addr_reg <= addr_next;
        end
    end

    // ****************************************
    // fetched bytes and operand
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            op1_reg <= RST_BYTE;
            op2_reg <= RST_BYTE;
            op3_reg <= RST_BYTE;
            disp_reg <= RST_BYTE;
            data_reg <= RST_BYTE;
            wdata_reg <= RST_BYTE;
        end else if (i_ce && t_cap) begin
            if (state_reg == ST_FETCH1) begin
                op1_reg <= i_mem_rdata;
            end
            if (state_reg == ST_FETCH2) begin
                op2_reg <= i_mem_rdata;
            end
            if (state_reg == ST_DISP) begin
                disp_reg <= i_mem_rdata;
            end
            if (state_reg == ST_FETCH3) begin
                op3_reg <= i_mem_rdata;
            end
            if (state_reg == ST_MREAD) begin
                data_reg <= i_mem_rdata;
            end
        end else if (i_ce && ev_mread_end) begin
            wdata_reg <= rot.result;
        end
    end

    // ****************************************
    // architectural registers
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            for (int i = 0; i <= int'(RIX_GPR_TOP); i++) begin
                gpr_reg[i] <= RST_BYTE;
            end
            flag_reg <= RST_BYTE;
        end else if (i_ce) begin
            if (sw_wr && (i_reg_addr <= RIX_GPR_TOP) && (i_reg_addr != RIX_FLAGS)) begin
                gpr_reg[i_reg_addr[FIELD_W-1:0]] <= i_reg_wdata;
            end
            if (sw_wr && (i_reg_addr == RIX_FLAGS)) begin
                flag_reg <= i_reg_wdata;
            end
            if (ev_acc) begin
                gpr_reg[FIELD_ACC] <= rot.result;
            end
            if (ev_reg) begin
                gpr_reg[field] <= rot.result;
            end
            if (ev_acc || ev_reg || ev_memw) begin
                flag_reg <= rot.flags_out;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            index_register_x_reg <= RST_WORD;
            index_register_y_reg <= RST_WORD;
            pc_reg <= RST_WORD;
        end else if (i_ce) begin
            if (sw_wr && (i_reg_addr == RIX_X_LO)) begin
                index_register_x_reg[DATA_W-1:0] <= i_reg_wdata;
            end
            if (sw_wr && (i_reg_addr == RIX_X_HI)) begin
                index_register_x_reg[ADDR_W-1:DATA_W] <= i_reg_wdata;
            end
            if (sw_wr && (i_reg_addr == RIX_Y_LO)) begin
                index_register_y_reg[DATA_W-1:0] <= i_reg_wdata;
            end
            if (sw_wr && (i_reg_addr == RIX_Y_HI)) begin
                index_register_y_reg[ADDR_W-1:DATA_W] <= i_reg_wdata;
            end
            if (sw_wr && (i_reg_addr == RIX_PC_LO)) begin
                pc_reg[DATA_W-1:0] <= i_reg_wdata;
            end
            if (sw_wr && (i_reg_addr == RIX_PC_HI)) begin
                pc_reg[ADDR_W-1:DATA_W] <= i_reg_wdata;
            end
            if (ev_cnt) begin
                index_register_y_reg <= index_register_y_reg - ADDR_W'(1);
            end
            if (ev_pc_inc) begin
                pc_reg <= pc_reg + ADDR_W'(1);
            end
        end
    end

    // ****************************************
    // control and status
    // ****************************************
    wire ctrl_wr = i_ce && i_reg_wr && (i_reg_addr == RIX_CTRL);
    wire stat_clr = i_ce && i_reg_wr && (i_reg_addr == RIX_STATUS) && i_reg_wdata[STAT_ILLEGAL];

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            run_reg <= 1'b0;
            illegal_reg <= 1'b0;
        end else if (i_ce) begin
            if (ctrl_wr) begin
                run_reg <= i_reg_wdata[CTRL_RUN];
            end else if (ev_bad) begin
                run_reg <= 1'b0;
            end
            if (ev_bad) begin
                illegal_reg <= 1'b1;
            end else if (stat_clr) begin
                illegal_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // software read port
    // ****************************************
    wire [DATA_W-1:0] status_word =
        DATA_W'({run_reg, illegal_reg, !is_idle});
    wire [DATA_W-1:0] rd_mux =
        (i_reg_addr == RIX_FLAGS) ? flag_reg :
        (i_reg_addr <= RIX_GPR_TOP) ? gpr_reg[i_reg_addr[FIELD_W-1:0]] :
        (i_reg_addr == RIX_X_LO) ? index_register_x_reg[DATA_W-1:0] :
        (i_reg_addr == RIX_X_HI) ? index_register_x_reg[ADDR_W-1:DATA_W] :
        (i_reg_addr == RIX_Y_LO) ? index_register_y_reg[DATA_W-1:0] :
        (i_reg_addr == RIX_Y_HI) ? index_register_y_reg[ADDR_W-1:DATA_W] :
        (i_reg_addr == RIX_PC_LO) ? pc_reg[DATA_W-1:0] :
        (i_reg_addr == RIX_PC_HI) ? pc_reg[ADDR_W-1:DATA_W] :
        (i_reg_addr == RIX_CTRL) ? DATA_W'(run_reg) :
        status_word;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rdata_reg <= RST_BYTE;
        end else if (i_ce) begin
            rdata_reg <= i_reg_rd ? rd_mux : RST_BYTE;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_reg_rdata = rdata_reg;
    assign o_mem_addr = addr_reg;
    assign o_mem_rd = i_ce && t_first && (ev_fetch || (state_reg == ST_MREAD));
    assign o_mem_wr = i_ce && t_first && (state_reg == ST_MWRITE);
    assign o_mem_wdata = wdata_reg;
    assign o_busy = !is_idle;

endmodule

// ===== rgd_asserts.sv
// port checker for the rotate group datapath
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module rgd_asserts (
    // watched ports
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_reg_rd,
    input wire logic [rgd_pkg::DATA_W-1:0] o_reg_rdata,
    input wire logic [rgd_pkg::ADDR_W-1:0] o_mem_addr,
    input wire logic o_mem_rd,
    input wire logic o_mem_wr,
    input wire logic o_busy
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    strobe_excl_a: assert property (!(o_mem_rd && o_mem_wr))
        else $error("memory read and write together");
    wb_after_read_a: assert property (o_mem_wr |-> $past(o_mem_rd, 4))
        else $error("write-back not four cycles after read");
    wb_same_addr_a: assert property (o_mem_wr |-> o_mem_addr == $past(o_mem_addr, 4))
        else $error("write-back address differs from read");
    cycle_min_a: assert property (o_mem_rd |=> !o_mem_rd [*2])
        else $error("machine cycle shorter than three");
    addr_hold_a: assert property (o_mem_rd |=> $stable(o_mem_addr) [*2])
        else $error("address moved inside machine cycle");
    idle_quiet_a: assert property (!o_busy |-> !o_mem_rd && !o_mem_wr)
        else $error("bus strobe while idle");
    rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    reset_clean_a: assert property ($fell(i_sys_rst) |-> !o_busy && o_mem_addr == 16'h0000)
        else $error("state not clean after reset");
    cover property (o_mem_wr);
    cover property (i_reg_rd ##1 o_reg_rdata != 8'h00);
    cover property ($fell(o_busy));
endmodule
bind rgd_datapath rgd_asserts chk_u (.i_clk, .i_sys_rst, .i_reg_rd, .o_reg_rdata,
    .o_mem_addr, .o_mem_rd, .o_mem_wr, .o_busy);

// ===== rgd_mem_model.sv
// byte memory on the datapath's memory bus
// answers a read in the next cycle, scrambled otherwise
`timescale 1ns/1ps
module rgd_mem_model (
    // bus from the datapath
    input wire logic i_clk,
    input wire logic [rgd_pkg::ADDR_W-1:0] i_mem_addr,
    input wire logic i_mem_rd,
    input wire logic i_mem_wr,
    input wire logic [rgd_pkg::DATA_W-1:0] i_mem_wdata,
    // read data
    output logic [rgd_pkg::DATA_W-1:0] o_mem_rdata
);
    logic [7:0] mem [0:65535];
    initial o_mem_rdata = 8'h5A;
    always @(posedge i_clk) begin
        if (i_mem_rd)
            o_mem_rdata <= mem[i_mem_addr];
        else
            o_mem_rdata <= ~o_mem_rdata;
        if (i_mem_wr)
            mem[i_mem_addr] <= i_mem_wdata;
    end
endmodule

// ===== tb_top.sv
// bench for the rotate group datapath
// assumes rgd_mem_model on the memory bus
`timescale 1ns/1ps
module tb_top;
    import rgd_pkg::*;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [3:0] i_reg_addr = 4'h0;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic i_ce = 1'b1;
    logic [7:0] o_reg_rdata, i_mem_rdata, o_mem_wdata;
    logic [15:0] o_mem_addr;
    logic o_mem_rd, o_mem_wr, o_busy;
    int errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int rdq[$];
    initial forever #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (o_mem_rd === 1'b1)
            rdq.push_back(cyc);
    end
    rgd_datapath dut_u (.i_clk, .i_sys_rst, .i_ce, .i_reg_addr, .i_reg_wdata,
        .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_mem_addr, .o_mem_rd, .o_mem_wr,
        .o_mem_wdata, .i_mem_rdata, .o_busy);
    rgd_mem_model mem_u (.i_clk, .i_mem_addr(o_mem_addr), .i_mem_rd(o_mem_rd),
        .i_mem_wr(o_mem_wr), .i_mem_wdata(o_mem_wdata), .o_mem_rdata(i_mem_rdata));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", errors, total_checks);
        if (errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic ckr(input string n, input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        #1 chk(n, e, o_reg_rdata);
    endtask
    task automatic run(input logic [15:0] pc, input logic [7:0] prog[$]);
        int n = 0;
        foreach (prog[i])
            mem_u.mem[pc + 16'(i)] = prog[i];
        wr(RIX_PC_LO, pc[7:0]);
        wr(RIX_PC_HI, pc[15:8]);
        rdq.delete();
        wr(RIX_CTRL, 8'h01);
        repeat (2) @(posedge i_clk);
        while (o_busy === 1'b1 && n < 300) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 300) begin
            errors++;
            finish_test();
        end
        ckr("status", RIX_STATUS, 8'h02);
        wr(RIX_STATUS, 8'h02);
    endtask
    task automatic gaps(input int e[$]);
        chk("fetches", 16'(e.size() + 1), 16'(rdq.size()));
        foreach (e[i])
            if (i + 1 < rdq.size())
                chk("gap", 16'(e[i]), 16'(rdq[i + 1] - rdq[i]));
    endtask
    task automatic t_acc();
        wr(RIX_GPR_TOP, 8'h88);
        wr(RIX_FLAGS, 8'hD6);
        run(16'h0100, '{8'h07, 8'h17, 8'h0F, 8'h1F, 8'h00});
        gaps('{4, 4, 4, 4});
        ckr("acc", RIX_GPR_TOP, 8'hC8);
        ckr("flags", RIX_FLAGS, 8'hC5);
    endtask
    task automatic t_ydec();
        wr(RIX_Y_LO, 8'h00);
        wr(RIX_Y_HI, 8'h00);
        wr(RIX_FLAGS, 8'hFF);
        run(16'h0200, '{8'hFD, 8'h2B, 8'h00});
        gaps('{4, 6});
        ckr("y lo", RIX_Y_LO, 8'hFF);
        ckr("y hi", RIX_Y_HI, 8'hFF);
        ckr("flags", RIX_FLAGS, 8'hFF);
        run(16'h0280, '{8'hDD, 8'h2B});
        gaps('{4});
        ckr("x lo", RIX_X_LO, 8'h00);
    endtask
    task automatic t_freeze();
        @(posedge i_clk);
        i_ce <= 1'b0;
        wr(RIX_Y_LO, 8'h55);
        @(posedge i_clk);
        i_ce <= 1'b1;
        ckr("frozen", RIX_Y_LO, 8'hFF);
    endtask
    task automatic t_reg();
        logic [3:0] r;
        for (int i = 0; i < 8; i++) begin
            if (i == 6)
                continue;
            r = 4'(i);
            wr(r, i[0] ? 8'h80 : 8'hC3);
            wr(RIX_FLAGS, 8'h12);
            run(16'h0300, '{8'hCB, {5'h00, r[2:0]}, 8'h00});
            gaps('{4, 4});
            ckr("reg", r, i[0] ? 8'h01 : 8'h87);
            ckr("flags", RIX_FLAGS, i[0] ? 8'h01 : 8'h85);
        end
    endtask
    task automatic t_mem();
        wr(4'h4, 8'h12);
        wr(4'h5, 8'h34);
        wr(RIX_FLAGS, 8'h12);
        mem_u.mem[16'h1234] = 8'hC3;
        run(16'h0400, '{8'hCB, 8'h06, 8'h00});
        gaps('{4, 4, 7});
        chk("mem", 8'h87, mem_u.mem[16'h1234]);
        ckr("flags", RIX_FLAGS, 8'h85);
        ckr("pc lo", RIX_PC_LO, 8'h03);
    endtask
    task automatic t_idx();
        wr(RIX_X_HI, 8'h10);
        wr(RIX_X_LO, 8'h00);
        wr(RIX_Y_HI, 8'h20);
        wr(RIX_Y_LO, 8'h00);
        mem_u.mem[16'h0FFE] = 8'h00;
        mem_u.mem[16'h2002] = 8'h80;
        run(16'h0500, '{8'hDD, 8'hCB, 8'hFE, 8'h06, 8'h00});
        gaps('{4, 4, 3, 5, 7});
        ckr("flags", RIX_FLAGS, 8'h44);
        run(16'h0600, '{8'hFD, 8'hCB, 8'h02, 8'h06, 8'h00});
        gaps('{4, 4, 3, 5, 7});
        chk("y mem", 8'h01, mem_u.mem[16'h2002]);
        ckr("flags", RIX_FLAGS, 8'h01);
    endtask
    initial begin
        repeat (20) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        t_acc();
        t_ydec();
        t_freeze();
        t_reg();
        t_mem();
        t_idx();
        finish_test();
    end
endmodule
